// ### src/serial_register_access_slave.sv
// Operation
// - Address 0011110b with select high, else 0011100b.
// - Address byte: seven address bits, then direction.
// - Acknowledge every received byte when addressed.
// - Release data for ack; hold low whole high.
// - Sub-address: low 7 index, top bit increments.
// - Write bytes acknowledged, successive with auto-increment.
// - Bytes eight bits, MSB first, unlimited count.
// - Receiver may stretch clock low to stall; this slave has no clock output and never stretches.
// - Detect start and stop while clock high.
// - Unaccepted address leaves data line high.
// - Outputs change on falling, sampled on rising.
// - SPI access 16 pulses, plus 8 per further register.
// - Frame bit 0 at first falling edge.
// - Bit 1 set advances index per block.
// - Bits 2-7 index, bits 8-15 data, MSB first.
// - Three-wire select bit at 22h enables 3-wire.
`timescale 1ns/1ns
`default_nettype none

module serial_register_access_slave
   import serial_access_pkg::*;
(
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   input wire logic i_clk_en,
   input wire logic i_cs_n,
   input wire logic i_scl_spc,
   input wire logic i_sda_sdi,
   input wire logic i_sdo_address_select_pin,
   input wire logic [7:0] i_reg_rdata,
   output logic o_sda_sdi_oe,
   output logic o_sda_sdi_out,
   output logic o_sdo_oe,
   output logic o_sdo_out,
   output logic [6:0] o_reg_index,
   output logic [7:0] o_reg_wdata,
   output logic o_reg_wr,
   output logic o_reg_rd,
   output logic o_three_wire_select
);

   // ------------------------------------------------------------------
   // Pin synchronisers and edge detection
   // ------------------------------------------------------------------
   logic [1:0] cs_sync_reg;
   logic [1:0] clk_sync_reg;
   logic [1:0] dat_sync_reg;
   logic [1:0] sel_sync_reg;
   logic cs_d_reg;
   logic clk_d_reg;
   logic dat_d_reg;

   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rst_n)
      begin
         cs_sync_reg <= 2'h3;
         clk_sync_reg <= 2'h3;
         dat_sync_reg <= 2'h3;
         sel_sync_reg <= 2'h0;
         cs_d_reg <= 1'b1;
         clk_d_reg <= 1'b1;
         dat_d_reg <= 1'b1;
      end
      else if (i_clk_en)
      begin
         cs_sync_reg <= {cs_sync_reg[0], i_cs_n};
         clk_sync_reg <= {clk_sync_reg[0], i_scl_spc};
         dat_sync_reg <= {dat_sync_reg[0], i_sda_sdi};
         sel_sync_reg <= {sel_sync_reg[0], i_sdo_address_select_pin};
         cs_d_reg <= cs_sync_reg[1];
         clk_d_reg <= clk_sync_reg[1];
         dat_d_reg <= dat_sync_reg[1];
      end
   end

   logic cs_n;
   logic clk_s;
   logic dat_s;
   logic clk_rise;
   logic clk_fall;
   logic i2c_mode;
   logic start_det;
   logic stop_det;
   logic [6:0] my_addr;

   assign cs_n = cs_sync_reg[1];
   assign clk_s = clk_sync_reg[1];
   assign dat_s = dat_sync_reg[1];
   assign clk_rise = clk_s && !clk_d_reg;
   assign clk_fall = !clk_s && clk_d_reg;
   assign i2c_mode = cs_n && cs_d_reg;
   assign start_det = i2c_mode && clk_s && clk_d_reg && dat_d_reg && !dat_s;
   assign stop_det = i2c_mode && clk_s && clk_d_reg && !dat_d_reg && dat_s;
   assign my_addr = sel_sync_reg[1] ? I2C_ADDR_SEL_HIGH : I2C_ADDR_SEL_LOW;

   // ------------------------------------------------------------------
   // Shared register-file strobes and index
   // ------------------------------------------------------------------
   logic i2c_wr;
   logic i2c_rd;
   logic i2c_set_idx;
   logic i2c_inc;
   logic spi_wr;
   logic spi_rd;
   logic spi_set_idx;
   logic spi_inc;
   logic [6:0] i2c_idx;
   logic [6:0] spi_idx;
   logic [7:0] i2c_wbyte;
   logic [7:0] spi_wbyte;
   logic inc_en_reg;
   logic spi_inc_en;

   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rst_n)
      begin
         o_reg_index <= 7'h00;
         inc_en_reg <= 1'b0;
      end
      else if (i_clk_en)
      begin
         if (i2c_set_idx)
         begin
            o_reg_index <= i2c_idx;
            inc_en_reg <= i2c_wbyte[7];
         end
         else if (spi_set_idx)
         begin
            o_reg_index <= spi_idx;
            inc_en_reg <= spi_inc_en;
         end
         else if ((i2c_inc || spi_inc) && inc_en_reg)
            o_reg_index <= o_reg_index + 7'h01;
      end
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rst_n)
      begin
         o_reg_wr <= 1'b0;
         o_reg_rd <= 1'b0;
         o_reg_wdata <= 8'h00;
      end
      else if (i_clk_en)
      begin
         o_reg_wr <= i2c_wr || spi_wr;
         o_reg_rd <= i2c_rd || spi_rd;
         if (i2c_wr)
            o_reg_wdata <= i2c_wbyte;
         else if (spi_wr)
            o_reg_wdata <= spi_wbyte;
      end
   end

   // Local copy of the three-wire select bit, tracked on writes to 22h.
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rst_n)
         o_three_wire_select <= IF_CTRL_RESET[IF_CTRL_THREE_WIRE_BIT];
      else if (i_clk_en && o_reg_wr && o_reg_index == IF_CTRL_INDEX)
         o_three_wire_select <= o_reg_wdata[IF_CTRL_THREE_WIRE_BIT];
   end

   // ------------------------------------------------------------------
   // I2C engine
   // ------------------------------------------------------------------
   i2c_state_t i2c_state_reg;
   logic [3:0] i2c_bit_reg;
   logic [7:0] i2c_shift_reg;
   logic i2c_rnw_reg;
   logic i2c_sda_low_reg;

   assign i2c_wbyte = i2c_shift_reg;
   assign i2c_idx = i2c_shift_reg[6:0];
   assign i2c_set_idx = clk_fall && i2c_state_reg == I2C_SUB && i2c_bit_reg == 4'h8;
   assign i2c_wr = clk_fall && i2c_state_reg == I2C_WDATA && i2c_bit_reg == 4'h8;
   assign i2c_rd = clk_fall && ((i2c_state_reg == I2C_ADDR_ACK && i2c_rnw_reg)
                   || (i2c_state_reg == I2C_RDATA_ACK && !dat_d_reg));
   assign i2c_inc = (i2c_state_reg == I2C_WDATA_ACK && clk_fall)
                    || (i2c_state_reg == I2C_RDATA && clk_rise && i2c_bit_reg == 4'h0);

   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rst_n)
      begin
         i2c_state_reg <= I2C_IDLE;
         i2c_bit_reg <= 4'h0;
         i2c_shift_reg <= 8'h00;
         i2c_rnw_reg <= 1'b0;
         i2c_sda_low_reg <= 1'b0;
      end
      else if (i_clk_en)
      begin
         if (!i2c_mode || stop_det)
         begin
            i2c_state_reg <= I2C_IDLE;
            i2c_sda_low_reg <= 1'b0;
         end
         else if (start_det)
         begin
            i2c_state_reg <= I2C_ADDR;
            i2c_bit_reg <= 4'h0;
            i2c_sda_low_reg <= 1'b0;
         end
         else if (clk_rise)
         begin
            case (i2c_state_reg)
               I2C_ADDR, I2C_SUB, I2C_WDATA:
               begin
                  i2c_shift_reg <= {i2c_shift_reg[6:0], dat_s};
                  i2c_bit_reg <= i2c_bit_reg + 4'h1;
               end
               I2C_RDATA_ACK:
                  if (dat_s)
                     i2c_state_reg <= I2C_IGNORE;
               default:
                  i2c_state_reg <= i2c_state_reg;
            endcase
         end
         else if (clk_fall)
         begin
            case (i2c_state_reg)
               I2C_ADDR:
                  if (i2c_bit_reg == 4'h8)
                  begin
                     if (i2c_shift_reg[7:1] == my_addr)
                     begin
                        i2c_rnw_reg <= i2c_shift_reg[0];
                        i2c_state_reg <= I2C_ADDR_ACK;
                        i2c_sda_low_reg <= 1'b1;
                     end
                     else
                        i2c_state_reg <= I2C_IGNORE;
                  end
               I2C_ADDR_ACK:
               begin
                  i2c_bit_reg <= 4'h0;
                  if (i2c_rnw_reg)
                  begin
                     i2c_state_reg <= I2C_RDATA;
                     i2c_shift_reg <= i_reg_rdata;
                     i2c_sda_low_reg <= !i_reg_rdata[7];
                  end
                  else
                  begin
                     i2c_state_reg <= I2C_SUB;
                     i2c_sda_low_reg <= 1'b0;
                  end
               end
               I2C_SUB, I2C_WDATA:
                  if (i2c_bit_reg == 4'h8)
                  begin
                     i2c_state_reg <= (i2c_state_reg == I2C_SUB) ? I2C_SUB_ACK : I2C_WDATA_ACK;
                     i2c_sda_low_reg <= 1'b1;
                  end
               I2C_SUB_ACK, I2C_WDATA_ACK:
               begin
                  i2c_state_reg <= I2C_WDATA;
                  i2c_bit_reg <= 4'h0;
                  i2c_sda_low_reg <= 1'b0;
               end
               I2C_RDATA:
               begin
                  if (i2c_bit_reg == 4'h7)
                  begin
                     i2c_state_reg <= I2C_RDATA_ACK;
                     i2c_sda_low_reg <= 1'b0;
                  end
                  else
                  begin
                     i2c_sda_low_reg <= !i2c_shift_reg[6];
                     i2c_shift_reg <= {i2c_shift_reg[6:0], 1'b0};
                  end
                  i2c_bit_reg <= i2c_bit_reg + 4'h1;
               end
               I2C_RDATA_ACK:
               begin
                  i2c_state_reg <= I2C_RDATA;
                  i2c_bit_reg <= 4'h0;
                  i2c_shift_reg <= i_reg_rdata;
                  i2c_sda_low_reg <= !i_reg_rdata[7];
               end
               default:
                  i2c_state_reg <= i2c_state_reg;
            endcase
         end
      end
   end

   // ------------------------------------------------------------------
   // SPI engine
   // ------------------------------------------------------------------
   logic [5:0] spi_cnt_reg;
   logic [2:0] spi_blk_reg;
   logic [7:0] spi_shift_reg;
   logic spi_rnw_reg;
   logic spi_inc_reg;
   logic spi_drive_reg;
   logic spi_out_reg;
   logic spi_in_header;

   assign spi_in_header = spi_cnt_reg < SPI_HEADER_BITS;
   assign spi_inc_en = spi_inc_reg;
   assign spi_idx = {1'b0, spi_shift_reg[5:0]};
   // The last bit of a block is merged as it arrives, so the write carries all eight bits.
   assign spi_wbyte = {spi_shift_reg[6:0], dat_s};
   assign spi_set_idx = !cs_n && clk_fall && spi_cnt_reg == SPI_FIRST_DATA_BIT;
   assign spi_rd = spi_set_idx && spi_rnw_reg;
   assign spi_wr = !cs_n && clk_rise && !spi_in_header && !spi_rnw_reg
                   && spi_cnt_reg != SPI_FIRST_DATA_BIT && spi_blk_reg == 3'h0;
   assign spi_inc = !cs_n && clk_fall && !spi_in_header && spi_blk_reg == 3'h0
                    && spi_cnt_reg != SPI_FIRST_DATA_BIT;

   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rst_n)
      begin
         spi_cnt_reg <= 6'h00;
         spi_blk_reg <= 3'h0;
         spi_shift_reg <= 8'h00;
         spi_rnw_reg <= 1'b0;
         spi_inc_reg <= 1'b0;
      end
      else if (i_clk_en)
      begin
         if (cs_n)
         begin
            spi_cnt_reg <= 6'h00;
            spi_blk_reg <= 3'h0;
         end
         else if (clk_fall)
         begin
            if (spi_in_header)
               spi_cnt_reg <= spi_cnt_reg + 6'h01;
            else
               spi_blk_reg <= spi_blk_reg + 3'h1;
            if (spi_cnt_reg == SPI_HEADER_BITS)
               spi_cnt_reg <= spi_cnt_reg + 6'h01;
            if (!spi_in_header && spi_rnw_reg && spi_blk_reg == 3'h0 && spi_cnt_reg != SPI_FIRST_DATA_BIT)
               spi_shift_reg <= i_reg_rdata;
         end
         else if (clk_rise)
         begin
            if (spi_cnt_reg == 6'h01 + SPI_BIT_DIR)
               spi_rnw_reg <= dat_s;
            if (spi_cnt_reg == 6'h01 + SPI_BIT_INC)
               spi_inc_reg <= dat_s;
            if (spi_cnt_reg > SPI_BIT_INC + 6'h01 && spi_cnt_reg <= SPI_BIT_ADDR_LAST + 6'h01)
               spi_shift_reg <= {spi_shift_reg[6:0], dat_s};
            else if (!spi_in_header && !spi_rnw_reg)
               spi_shift_reg <= {spi_shift_reg[6:0], dat_s};
         end
      end
   end

   // Read bits shift out on falling edges, from the start of bit 8 onward.
   // A block's first byte is fetched one cycle after its falling edge, once the index has settled.
   logic [7:0] spi_rdbyte_reg;
   logic spi_load_reg;

   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rst_n)
      begin
         spi_drive_reg <= 1'b0;
         spi_out_reg <= 1'b1;
         spi_rdbyte_reg <= 8'h00;
         spi_load_reg <= 1'b0;
      end
      else if (i_clk_en)
      begin
         spi_load_reg <= 1'b0;
         if (cs_n)
            spi_drive_reg <= 1'b0;
         else if (spi_load_reg)
         begin
            spi_out_reg <= i_reg_rdata[7];
            spi_rdbyte_reg <= {i_reg_rdata[6:0], 1'b0};
         end
         else if (clk_fall && !spi_in_header && spi_rnw_reg)
         begin
            spi_drive_reg <= 1'b1;
            if (spi_blk_reg == 3'h0)
               spi_load_reg <= 1'b1;
            else
            begin
               spi_out_reg <= spi_rdbyte_reg[7];
               spi_rdbyte_reg <= {spi_rdbyte_reg[6:0], 1'b0};
            end
         end
      end
   end

   // ------------------------------------------------------------------
   // Pad drivers
   // ------------------------------------------------------------------
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rst_n)
      begin
         o_sda_sdi_oe <= 1'b0;
         o_sda_sdi_out <= 1'b0;
         o_sdo_oe <= 1'b0;
         o_sdo_out <= 1'b1;
      end
      else if (i_clk_en)
      begin
         if (i2c_mode)
         begin
            o_sda_sdi_oe <= i2c_sda_low_reg;
            o_sda_sdi_out <= 1'b0;
            o_sdo_oe <= 1'b0;
         end
         else
         begin
            o_sda_sdi_oe <= o_three_wire_select && spi_drive_reg;
            o_sda_sdi_out <= spi_out_reg;
            o_sdo_oe <= !o_three_wire_select && spi_drive_reg;
         end
         o_sdo_out <= spi_out_reg;
      end
   end

endmodule // serial_register_access_slave

`default_nettype wire

// ### src/serial_access_pkg.sv
package serial_access_pkg;

   // ------------------------------------------------------------------
   // I2C addressing
   // ------------------------------------------------------------------
   localparam logic [6:0] I2C_ADDR_SEL_HIGH = 7'h1e;
   localparam logic [6:0] I2C_ADDR_SEL_LOW = 7'h1c;
   localparam int I2C_BITS_PER_BYTE = 8;

   // ------------------------------------------------------------------
   // SPI frame layout
   // ------------------------------------------------------------------
   localparam logic [5:0] SPI_BIT_DIR = 6'h00;
   localparam logic [5:0] SPI_BIT_INC = 6'h01;
   localparam logic [5:0] SPI_BIT_ADDR_LAST = 6'h07;
   localparam logic [5:0] SPI_FIRST_DATA_BIT = 6'h08;
   localparam logic [5:0] SPI_HEADER_BITS = 6'h08;
   localparam logic [2:0] SPI_BLOCK_LAST = 3'h7;

   // ------------------------------------------------------------------
   // Register file
   // ------------------------------------------------------------------
   localparam logic [6:0] IF_CTRL_INDEX = 7'h22;
   localparam int IF_CTRL_THREE_WIRE_BIT = 2;
   localparam logic [7:0] IF_CTRL_RESET = 8'h03;

   typedef enum logic [3:0] {
      I2C_IDLE = 4'h0,
      I2C_ADDR = 4'h1,
      I2C_ADDR_ACK = 4'h3,
      I2C_SUB = 4'h2,
      I2C_SUB_ACK = 4'h6,
      I2C_WDATA = 4'h7,
      I2C_WDATA_ACK = 4'h5,
      I2C_RDATA = 4'h4,
      I2C_RDATA_ACK = 4'hc,
      I2C_IGNORE = 4'hd
   } i2c_state_t;

endpackage

// ### tb/serial_access_chk.sv
`timescale 1ns/1ns
`default_nettype none
module serial_access_chk
   import serial_access_pkg::*;
(
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   input wire logic i_cs_n,
   input wire logic i_scl_spc,
   input wire logic o_sda_sdi_oe,
   input wire logic o_sda_sdi_out,
   input wire logic o_sdo_oe,
   input wire logic o_sdo_out,
   input wire logic [6:0] o_reg_index,
   input wire logic [7:0] o_reg_wdata,
   input wire logic o_reg_wr,
   input wire logic o_three_wire_select
);
   // Counts how long chip select has been high, so I2C mode is trusted only after the sync delay.
   logic [3:0] cs_high_reg;
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rst_n || !i_cs_n)
         cs_high_reg <= 4'h0;
      else if (cs_high_reg != 4'hf)
         cs_high_reg <= cs_high_reg + 4'h1;
   end
   wire i2c_mode = cs_high_reg > 4'h6;
   wire ctrl_wr = o_reg_wr && (o_reg_index == IF_CTRL_INDEX);
   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (!i_rst_n);
   sequence s_bit_held;
      o_sda_sdi_oe [*4];
   endsequence
   a_open_drain: assert property (i2c_mode && o_sda_sdi_oe |-> !o_sda_sdi_out)
      else $error("sda driven high in i2c");
   a_ack_held: assert property (i2c_mode && o_sda_sdi_oe && $rose(i_scl_spc) |-> s_bit_held)
      else $error("sda drive dropped while clock high");
   a_sdo_quiet_i2c: assert property (i2c_mode |-> !o_sdo_oe)
      else $error("sdo driven in i2c mode");
   a_cs_release: assert property ($rose(i_cs_n) |-> ##[1:6] (!o_sdo_oe && !o_sda_sdi_oe))
      else $error("data line not released after frame");
   a_wr_pulse: assert property (o_reg_wr |=> !o_reg_wr)
      else $error("write pulse longer than one cycle");
   a_ctrl_set: assert property (ctrl_wr |=> o_three_wire_select == $past(o_reg_wdata[IF_CTRL_THREE_WIRE_BIT]))
      else $error("three wire select not taken");
   a_ctrl_hold: assert property (!ctrl_wr |=> $stable(o_three_wire_select))
      else $error("three wire select moved");
   a_sdo_4wire: assert property (o_sdo_oe |-> !o_three_wire_select)
      else $error("sdo driven in three wire mode");
   a_out_on_fall: assert property (o_sdo_oe && $changed(o_sdo_out) || o_sda_sdi_oe && $changed(o_sda_sdi_out)
      |-> !i_scl_spc)
      else $error("output changed while clock high");
   a_header_quiet: assert property ($fell(i_cs_n) |-> (!o_sdo_oe && !o_sda_sdi_oe) [*8])
      else $error("output driven during header");
endmodule // serial_access_chk
bind serial_register_access_slave serial_access_chk u_chk (.i_ref_clk, .i_rst_n, .i_cs_n, .i_scl_spc,
   .o_sda_sdi_oe, .o_sda_sdi_out, .o_sdo_oe, .o_sdo_out, .o_reg_index, .o_reg_wdata, .o_reg_wr,
   .o_three_wire_select);
`default_nettype wire

// ### tb/serial_master_model.sv
`timescale 1ns/1ns
`default_nettype none
module serial_master_model
(
   input wire logic i_ref_clk,
   input wire logic i_sda,
   input wire logic i_sdo,
   output logic o_cs_n,
   output logic o_scl,
   output logic o_sda
);
   initial
   begin
      o_cs_n = 1'b1;
      o_scl = 1'b1;
      o_sda = 1'b1;
   end
   task automatic wait_clk(input int n);
      repeat (n) @(posedge i_ref_clk);
   endtask
   // Serves as START and as repeated START.
   task automatic i2c_start();
      wait_clk(4);
      o_sda <= 1'b1;
      wait_clk(4);
      o_scl <= 1'b1;
      wait_clk(4);
      o_sda <= 1'b0;
      wait_clk(4);
      o_scl <= 1'b0;
   endtask
   task automatic i2c_stop();
      wait_clk(4);
      o_sda <= 1'b0;
      wait_clk(4);
      o_scl <= 1'b1;
      wait_clk(4);
      o_sda <= 1'b1;
      wait_clk(16);
   endtask
   // Eight data bits then the acknowledge slot; a 1 releases the line.
   task automatic i2c_byte(input logic [8:0] tx, output logic [8:0] rx);
      for (int i = 8; i >= 0; i--)
      begin
         #31;
         o_sda <= tx[i];
         #31;
         o_scl <= 1'b1;
         #63;
         rx[i] = i_sda;
         o_scl <= 1'b0;
      end
   endtask
   task automatic spi_frame(input int nbits, input logic [31:0] tx, input logic w3, output logic [31:0] rx);
      rx = '0;
      wait_clk(1);
      o_cs_n <= 1'b0;
      wait_clk(8);
      for (int i = 0; i < nbits; i++)
      begin
         o_scl <= 1'b0;
         o_sda <= tx[31 - i];
         #63;
         o_scl <= 1'b1;
         rx[31 - i] = w3 ? i_sda : i_sdo;
         #62;
      end
      o_cs_n <= 1'b1;
      o_sda <= 1'b1;
      wait_clk(16);
   endtask
endmodule // serial_master_model
`default_nettype wire

// ### tb/serial_register_access_slave_tb.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(what, exp, got) \
   begin tests_run++; if ((got) !== (exp)) begin errors++; \
   $display("mismatch %s expected %h seen %h", what, exp, got); end end
module serial_register_access_slave_tb;
   import serial_access_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic strap = 1'b1;
   wire cs_n, scl, m_sda, sda_oe, sda_out, sdo_oe, sdo_out, wr, rd, three_wire;
   wire [6:0] idx;
   wire [7:0] wdata;
   wire sda_w = m_sda & (!sda_oe | sda_out);
   wire sdo_w = sdo_oe ? sdo_out : strap;
   logic [7:0] mem [128];
   wire [7:0] rdata = mem[idx];
   logic [14:0] wq [$];
   int errors = 0;
   int tests_run = 0;
   int rd_seen = 0;
   logic [8:0] rx9;
   logic [31:0] rx;
   logic [6:0] a;
   serial_register_access_slave u_serial_register_access_slave (.i_ref_clk(clk), .i_rst_n(rst_n),
      .i_clk_en(1'b1), .i_cs_n(cs_n), .i_scl_spc(scl), .i_sda_sdi(sda_w), .i_sdo_address_select_pin(sdo_w),
      .i_reg_rdata(rdata), .o_sda_sdi_oe(sda_oe), .o_sda_sdi_out(sda_out), .o_sdo_oe(sdo_oe),
      .o_sdo_out(sdo_out), .o_reg_index(idx), .o_reg_wdata(wdata), .o_reg_wr(wr), .o_reg_rd(rd),
      .o_three_wire_select(three_wire));
   serial_master_model u_serial_master_model (.i_ref_clk(clk), .i_sda(sda_w), .i_sdo(sdo_w),
      .o_cs_n(cs_n), .o_scl(scl), .o_sda(m_sda));
   initial
   begin
      forever #4 clk = ~clk;
   end
   function automatic logic [7:0] init_val(input logic [6:0] i);
      return 8'h5a ^ {1'b0, i};
   endfunction
   // ----------------------------------------
   // Register file stand-in
   // ----------------------------------------
   initial
   begin
      for (int i = 0; i < 128; i++)
         mem[i] = init_val(i[6:0]);
   end
   always @(posedge clk)
   begin
      if (rd === 1'b1)
         rd_seen++;
      if (wr === 1'b1)
      begin
         wq.push_back({idx, wdata});
         mem[idx] <= wdata;
      end
   end
   task automatic chk_wr(input logic [6:0] i, input logic [7:0] d);
      logic [14:0] got;
      got = (wq.size() > 0) ? wq.pop_front() : 15'h7fff;
      `CHK("reg write", {i, d}, got)
   endtask
   task automatic i2c_wr(input logic [7:0] b, input logic exp_n);
      u_serial_master_model.i2c_byte({b, 1'b1}, rx9);
      `CHK("ack slot", exp_n, rx9[0])
   endtask
   task automatic close_out();
      $display("counts errors %0d tests_run %0d", errors, tests_run);
      if (errors == 0 && tests_run > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   initial
   begin
      repeat (20000) @(posedge clk);
      errors++;
      close_out();
   end
   initial
   begin
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      repeat (8) @(posedge clk);
      for (int s = 1; s >= 0; s--)
      begin
         strap <= s[0];
         a = s[0] ? 7'h1e : 7'h1c;
         repeat (8) @(posedge clk);
         u_serial_master_model.i2c_start();
         i2c_wr({a ^ 7'h02, 1'b0}, 1'b1);
         u_serial_master_model.i2c_stop();
         u_serial_master_model.i2c_start();
         i2c_wr({a, 1'b0}, 1'b0);
         i2c_wr(8'ha0, 1'b0);
         i2c_wr(8'h11, 1'b0);
         i2c_wr(8'h22, 1'b0);
         u_serial_master_model.i2c_stop();
         chk_wr(7'h20, 8'h11);
         chk_wr(7'h21, 8'h22);
      end
      $display("test i2c_write done");
      for (int k = 1; k >= 0; k--)
      begin
         u_serial_master_model.i2c_start();
         i2c_wr(8'h38, 1'b0);
         i2c_wr({k[0], 7'h05}, 1'b0);
         u_serial_master_model.i2c_start();
         i2c_wr(8'h39, 1'b0);
         u_serial_master_model.i2c_byte({8'hff, 1'b0}, rx9);
         `CHK("i2c read 0", init_val(7'h05), rx9[8:1])
         u_serial_master_model.i2c_byte({8'hff, 1'b1}, rx9);
         `CHK("i2c read 1", init_val(7'h05 + {6'h00, k[0]}), rx9[8:1])
         u_serial_master_model.i2c_stop();
      end
      $display("test i2c_read done");
      for (int d = 1; d >= 0; d--)
         for (int k = 1; k >= 0; k--)
         begin
            u_serial_master_model.spi_frame(24, {d[0], k[0], 6'h10, d[0] ? 16'hffff : 16'haabb, 8'hff}, 1'b0, rx);
            if (d == 1)
            begin
               `CHK("spi read 0", init_val(7'h10), rx[23:16])
               `CHK("spi read 1", init_val(7'h10 + {6'h00, k[0]}), rx[15:8])
            end
            else
            begin
               chk_wr(7'h10, 8'haa);
               chk_wr(7'h10 + {6'h00, k[0]}, 8'hbb);
            end
         end
      $display("test spi_4wire done");
      u_serial_master_model.spi_frame(16, {8'h22, 8'h04, 16'h0000}, 1'b0, rx);
      chk_wr(7'h22, 8'h04);
      `CHK("three wire", 1'b1, three_wire)
      u_serial_master_model.spi_frame(24, {8'hca, 24'hffffff}, 1'b1, rx);
      `CHK("3w read 0", init_val(7'h0a), rx[23:16])
      `CHK("3w read 1", init_val(7'h0b), rx[15:8])
      `CHK("spare writes", 0, wq.size())
      `CHK("read strobes", 7, rd_seen)
      $display("test spi_3wire done");
      close_out();
   end
endmodule // serial_register_access_slave_tb
`default_nettype wire
